// ### hdl/ictx_shadow.sv
// One-deep shadow copies of the key CPU registers.
`timescale 1ns/1ps
module ictx_shadow (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link to the sequencer
    ictx_shadow_if.shadow sh
);
    typedef struct packed {
        ictx_pkg::ictx_regs_t shadow;
        ictx_pkg::ictx_regs_t restored;
        logic restore_valid;
        logic valid;
    } ictx_shadow_state_t;

    ictx_shadow_state_t q_ff;
    ictx_shadow_state_t nxt_q;
    ictx_pkg::ictx_regs_t back;

    // ------------------------------------------------------------------
    // Per-register restore value
    // ------------------------------------------------------------------
    // The disable and external flag bits never come back from the shadow.
    genvar gi;
    generate
        for (gi = 0; gi < ictx_pkg::NUM_SHADOW; gi++) begin : g_back
            always_comb begin
                back[gi] = q_ff.shadow[gi];
                if (gi == ictx_pkg::SH_STATUS0) begin
                    back[gi][ictx_pkg::DISABLE_BIT_POS] = ~sh.return_and_enable;
                end
                if (gi == ictx_pkg::SH_STATUS1) begin
                    back[gi][ictx_pkg::EXT_FLAG_BIT_POS] =
                        sh.live[gi][ictx_pkg::EXT_FLAG_BIT_POS];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.restore_valid = 1'b0;
        if (sh.save) begin
            // A second save before a return simply overwrites the entry.
            nxt_q.shadow = sh.live;
            nxt_q.valid = 1'b1;
        end else if (sh.restore) begin
            nxt_q.restored = back;
            nxt_q.restore_valid = 1'b1;
            nxt_q.valid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign sh.restored = q_ff.restored;
    assign sh.restore_valid = q_ff.restore_valid;
    assign sh.shadow_valid = q_ff.valid;
endmodule // ictx_shadow

// ### hdl/ictx_top.sv
// Interrupt entry sequencer with PC stack, context shadows and register slave.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module ictx_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt sources and bus hold
    input wire logic [ictx_pkg::NUM_INT-1:0] ext_int_n,
    input wire logic bus_hold_req_n,
    output logic bus_hold_grant_n,
    output logic int_acknowledge_n,
    // Decoder events
    input wire logic instr_done,
    input wire logic op_call,
    input wire logic op_ret,
    input wire logic op_return_from_interrupt,
    input wire logic op_return_and_enable,
    input wire logic op_set_global_disable,
    input wire logic op_clear_global_disable,
    input wire logic op_store_status_zero,
    input wire logic [ictx_pkg::REG_W-1:0] status_zero_in,
    input wire logic [ictx_pkg::PC_W-1:0] return_pc,
    input wire logic repeat_active,
    input wire logic multicycle_busy,
    input wire logic mem_wait,
    // Pipeline control
    output logic global_int_disable,
    output logic injected_trap_instr,
    output logic fetch_dummy,
    output logic vec_fetch,
    output logic [ictx_pkg::PC_W-1:0] vec_addr,
    output logic resume_valid,
    output logic [ictx_pkg::PC_W-1:0] resume_pc,
    output logic status_store_valid,
    output logic [ictx_pkg::REG_W-1:0] status_store_data,
    // Key registers
    input wire logic [ictx_pkg::NUM_SHADOW*ictx_pkg::REG_W-1:0] live_regs,
    output logic restore_valid,
    output logic [ictx_pkg::NUM_SHADOW*ictx_pkg::REG_W-1:0] restored_regs
);
    localparam int NI = ictx_pkg::NUM_INT;
    localparam int PW = ictx_pkg::PC_W;

    typedef struct packed {
        ictx_pkg::ictx_state_t state;
        logic [1:0] flush_cnt;
        logic [1:0] shield_cnt;
        logic [NI-1:0] sync1;
        logic [NI-1:0] sync2;
        logic [NI-1:0] sync3;
        logic [NI-1:0] sync_prev;
        logic [NI-1:0] pending;
        logic [NI-1:0] mask;
        logic hold_mode;
        logic vec_on_chip;
        logic [PW-1:0] vec_base;
        logic disable_int;
        logic hold_grant_n;
        logic int_acknowledge_n_n;
        logic inject;
        logic [PW-1:0] vec_addr;
        logic [1:0] cur_idx;
        logic [ictx_pkg::STACK_DEPTH-1:0][PW-1:0] stack;
        logic [3:0] depth;
        logic overflow;
        logic underflow;
        logic resume_valid;
        logic [PW-1:0] resume_pc;
        logic sst_valid;
        logic [ictx_pkg::REG_W-1:0] sst_data;
        logic dp_write;
        logic dp_read;
        logic dp_wait;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
    } ictx_core_t;

    ictx_core_t q_ff;
    ictx_core_t nxt_q;
    ictx_shadow_if sh_if ();

    logic take;
    logic hold_block;
    logic [NI-1:0] enabled;
    logic [NI-1:0] fall;
    logic [NI-1:0] clr;
    logic [1:0] sel_idx;
    logic push;
    logic pop;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    // ------------------------------------------------------------------
    // Trap decision
    // ------------------------------------------------------------------
    always_comb begin
        enabled = q_ff.pending & q_ff.mask;
        fall = ~q_ff.sync3 & q_ff.sync_prev;
        // Concurrent hold with on-chip vectors needs no external bus.
        hold_block = (~bus_hold_req_n | ~q_ff.hold_grant_n)
                     & ~(~q_ff.hold_mode & q_ff.vec_on_chip);
        take = (q_ff.state == ictx_pkg::ST_IDLE) && (|enabled) && !q_ff.disable_int
               && !repeat_active
               && !hold_block
               && (q_ff.shield_cnt == 2'h0);
        sel_idx = 2'h0;
        for (int i = NI - 1; i >= 0; i--) begin
            if (enabled[i]) begin
                sel_idx = 2'(i);
            end
        end
        push = take | op_call;
        pop = op_ret | op_return_from_interrupt | op_return_and_enable;
    end

    // ------------------------------------------------------------------
    // Register read data
    // ------------------------------------------------------------------
    always_comb begin
        status_word = '0;
        status_word[ictx_pkg::STAT_DISABLE_POS] = q_ff.disable_int;
        status_word[ictx_pkg::STAT_DEPTH_POS +: 4] = q_ff.depth;
        status_word[ictx_pkg::STAT_OVERFLOW_POS] = q_ff.overflow;
        status_word[ictx_pkg::STAT_UNDERFLOW_POS] = q_ff.underflow;
        status_word[ictx_pkg::STAT_SHADOW_VALID_POS] = sh_if.shadow_valid;
        status_word[ictx_pkg::STAT_BUSY_POS] = (q_ff.state != ictx_pkg::ST_IDLE);
        rd_mux = '0;
        unique case (q_ff.dp_addr)
            ictx_pkg::OFS_CTRL: begin
                rd_mux[ictx_pkg::CTRL_HOLD_MODE_POS] = q_ff.hold_mode;
                rd_mux[ictx_pkg::CTRL_VEC_ON_CHIP_POS] = q_ff.vec_on_chip;
            end
            ictx_pkg::OFS_MASK: rd_mux[NI-1:0] = q_ff.mask;
            ictx_pkg::OFS_PENDING: rd_mux[NI-1:0] = q_ff.pending;
            ictx_pkg::OFS_VEC_BASE: rd_mux[PW-1:0] = q_ff.vec_base;
            ictx_pkg::OFS_STATUS: rd_mux = status_word;
            ictx_pkg::OFS_TOS: begin
                if (q_ff.depth != 4'h0) begin
                    rd_mux[PW-1:0] = q_ff.stack[3'(q_ff.depth - 4'h1)];
                end
            end
            default: rd_mux = '0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.resume_valid = 1'b0;
        nxt_q.sst_valid = 1'b0;
        nxt_q.inject = 1'b0;

        // Three synchroniser stages ahead of the recognition cycle.
        nxt_q.sync1 = ext_int_n;
        nxt_q.sync2 = q_ff.sync1;
        nxt_q.sync3 = q_ff.sync2;
        nxt_q.sync_prev = q_ff.sync3;

        nxt_q.hold_grant_n = bus_hold_req_n;

        // Bus slave: reads take one wait state so the data comes from a flop.
        clr = '0;
        if (q_ff.dp_write) begin
            unique case (q_ff.dp_addr)
                ictx_pkg::OFS_CTRL: begin
                    nxt_q.hold_mode = hwdata[ictx_pkg::CTRL_HOLD_MODE_POS];
                    nxt_q.vec_on_chip = hwdata[ictx_pkg::CTRL_VEC_ON_CHIP_POS];
                end
                ictx_pkg::OFS_MASK: nxt_q.mask = hwdata[NI-1:0];
                ictx_pkg::OFS_PENDING: clr = hwdata[NI-1:0];
                ictx_pkg::OFS_VEC_BASE: nxt_q.vec_base = hwdata[PW-1:0];
                default: ;
            endcase
            nxt_q.dp_write = 1'b0;
        end
        if (q_ff.dp_read) begin
            if (q_ff.dp_wait) begin
                nxt_q.rdata = rd_mux;
                nxt_q.dp_wait = 1'b0;
            end else begin
                nxt_q.dp_read = 1'b0;
            end
        end
        if (hsel && hready && htrans[1]) begin
            nxt_q.dp_addr = haddr[7:0];
            nxt_q.dp_write = hwrite;
            nxt_q.dp_read = ~hwrite;
            nxt_q.dp_wait = ~hwrite;
        end

        // Pending flags: a new edge wins over any clear in the same cycle.
        if (take) begin
            clr[sel_idx] = 1'b1;
        end
        nxt_q.pending = (q_ff.pending & ~clr) | fall;

        // Instruction shield after a set or clear global disable instruction.
        if (op_clear_global_disable || op_set_global_disable) begin
            nxt_q.shield_cnt = ictx_pkg::SHIELD_INSTRS;
        end else if (instr_done && q_ff.shield_cnt != 2'h0) begin
            nxt_q.shield_cnt = q_ff.shield_cnt - 2'h1;
        end

        // Global disable: setting events win over clearing ones.
        if (op_clear_global_disable || op_return_and_enable) begin
            nxt_q.disable_int = 1'b0;
        end
        if (op_set_global_disable || take) begin
            nxt_q.disable_int = 1'b1;
        end

        if (op_store_status_zero) begin
            nxt_q.sst_valid = 1'b1;
            nxt_q.sst_data = status_zero_in;
            nxt_q.sst_data[ictx_pkg::DISABLE_BIT_POS] = q_ff.disable_int | take;
        end

        // PC stack; a push on a full stack is dropped and flagged.
        if (push) begin
            if (q_ff.depth == 4'(ictx_pkg::STACK_DEPTH)) begin
                nxt_q.overflow = 1'b1;
            end else begin
                nxt_q.stack[q_ff.depth[2:0]] = return_pc;
                nxt_q.depth = q_ff.depth + 4'h1;
            end
        end else if (pop) begin
            if (q_ff.depth == 4'h0) begin
                nxt_q.underflow = 1'b1;
            end else begin
                nxt_q.resume_pc = q_ff.stack[3'(q_ff.depth - 4'h1)];
                nxt_q.resume_valid = 1'b1;
                nxt_q.depth = q_ff.depth - 4'h1;
            end
        end

        // Trap sequence.
        unique case (q_ff.state)
            ictx_pkg::ST_IDLE: begin
                if (take) begin
                    nxt_q.state = ictx_pkg::ST_INJECT;
                    nxt_q.cur_idx = sel_idx;
                    nxt_q.inject = 1'b1;
                end
            end
            ictx_pkg::ST_INJECT: begin
                nxt_q.state = ictx_pkg::ST_FLUSH;
                nxt_q.flush_cnt = ictx_pkg::FLUSH_CYCLES - 2'h1;
            end
            ictx_pkg::ST_FLUSH: begin
                // Instructions already in flight finish before the vector fetch.
                if (!multicycle_busy) begin
                    if (q_ff.flush_cnt == 2'h0) begin
                        nxt_q.state = ictx_pkg::ST_ACK;
                        nxt_q.vec_addr = q_ff.vec_base + {13'h0000, q_ff.cur_idx, 1'b0};
                    end else begin
                        nxt_q.flush_cnt = q_ff.flush_cnt - 2'h1;
                    end
                end
            end
            ictx_pkg::ST_ACK: begin
                if (!mem_wait) begin
                    nxt_q.state = ictx_pkg::ST_IDLE;
                end
            end
        endcase
        nxt_q.int_acknowledge_n_n = (nxt_q.state != ictx_pkg::ST_ACK);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= '0;
            q_ff.state <= ictx_pkg::ST_IDLE;
            q_ff.sync1 <= '1;
            q_ff.sync2 <= '1;
            q_ff.sync3 <= '1;
            q_ff.sync_prev <= '1;
            q_ff.mask <= ictx_pkg::RST_MASK;
            q_ff.hold_mode <= ictx_pkg::RST_HOLD_MODE;
            q_ff.vec_on_chip <= ictx_pkg::RST_VEC_ON_CHIP;
            q_ff.vec_base <= ictx_pkg::RST_VEC_BASE;
            q_ff.disable_int <= ictx_pkg::RST_DISABLE;
            q_ff.hold_grant_n <= 1'b1;
            q_ff.int_acknowledge_n_n <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------------
    // Shadow register file
    // ------------------------------------------------------------------
    // Only the maskable trap drives the save; a nonmaskable entry has no path here.
    assign sh_if.save = take;
    assign sh_if.restore = op_return_from_interrupt | op_return_and_enable;
    assign sh_if.return_and_enable = op_return_and_enable;
    assign sh_if.live = live_regs;

    ictx_shadow u_shadow (
        .clk(clk),
        .rst_b(rst_b),
        .sh(sh_if.shadow)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hreadyout = ~q_ff.dp_wait;
    assign hresp = 1'b0;
    assign hrdata = q_ff.rdata;
    assign bus_hold_grant_n = q_ff.hold_grant_n;
    assign int_acknowledge_n = q_ff.int_acknowledge_n_n;
    assign global_int_disable = q_ff.disable_int;
    assign injected_trap_instr = q_ff.inject;
    assign fetch_dummy = (q_ff.state != ictx_pkg::ST_IDLE);
    assign vec_fetch = ~q_ff.int_acknowledge_n_n;
    assign vec_addr = q_ff.vec_addr;
    assign resume_valid = q_ff.resume_valid;
    assign resume_pc = q_ff.resume_pc;
    assign status_store_valid = q_ff.sst_valid;
    assign status_store_data = q_ff.sst_data;
    assign restore_valid = sh_if.restore_valid;
    assign restored_regs = sh_if.restored;
endmodule // ictx_top

// ### pkg/ictx_pkg.sv
// Shared constants, register map and types of the interrupt context block.
package ictx_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_INT = 4;
    localparam int PC_W = 16;
    localparam int STACK_DEPTH = 8;
    localparam int NUM_SHADOW = 11;
    localparam int REG_W = 32;

    // ------------------------------------------------------------------
    // Timing counts in clock cycles (flush) and instructions (shield)
    // ------------------------------------------------------------------
    localparam logic [1:0] FLUSH_CYCLES = 2'h2;
    localparam logic [1:0] SHIELD_INSTRS = 2'h2;

    // ------------------------------------------------------------------
    // Shadowed register slots and protected bits
    // ------------------------------------------------------------------
    localparam int SH_ACC = 0;
    localparam int SH_ACC_BUF = 1;
    localparam int SH_AUX_CMP = 2;
    localparam int SH_INDEX = 3;
    localparam int SH_MODE_STATUS = 4;
    localparam int SH_PRODUCT = 5;
    localparam int SH_STATUS0 = 6;
    localparam int SH_STATUS1 = 7;
    localparam int SH_MULT_TEMP = 8;
    localparam int SH_SHIFT_TEMP = 9;
    localparam int SH_BIT_TEMP = 10;
    localparam int DISABLE_BIT_POS = 0;
    localparam int EXT_FLAG_BIT_POS = 0;

    // ------------------------------------------------------------------
    // Register byte offsets and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_PENDING = 8'h08;
    localparam logic [7:0] OFS_VEC_BASE = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_TOS = 8'h14;
    localparam int CTRL_HOLD_MODE_POS = 0;
    localparam int CTRL_VEC_ON_CHIP_POS = 1;
    localparam int STAT_DISABLE_POS = 0;
    localparam int STAT_DEPTH_POS = 4;
    localparam int STAT_OVERFLOW_POS = 8;
    localparam int STAT_UNDERFLOW_POS = 9;
    localparam int STAT_SHADOW_VALID_POS = 10;
    localparam int STAT_BUSY_POS = 11;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_HOLD_MODE = 1'b1;
    localparam logic RST_VEC_ON_CHIP = 1'b0;
    localparam logic RST_DISABLE = 1'b1;
    localparam logic [NUM_INT-1:0] RST_MASK = 4'h0;
    localparam logic [PC_W-1:0] RST_VEC_BASE = 16'h0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_INJECT, ST_FLUSH, ST_ACK} ictx_state_t;
    typedef logic [NUM_SHADOW-1:0][REG_W-1:0] ictx_regs_t;

endpackage

// ### pkg/ictx_shadow_if.sv
// Carrier between the trap sequencer and the shadow register file.
`timescale 1ns/1ps
interface ictx_shadow_if;
    logic save;
    logic restore;
    logic return_and_enable;
    ictx_pkg::ictx_regs_t live;
    ictx_pkg::ictx_regs_t restored;
    logic restore_valid;
    logic shadow_valid;

    modport core (output save, output restore, output return_and_enable, output live,
                  input restored, input restore_valid, input shadow_valid);
    modport shadow (input save, input restore, input return_and_enable, input live,
                    output restored, output restore_valid, output shadow_valid);
endinterface

// ### testbench/ictx_monitor.sv
// Port checker of the interrupt context block.
`timescale 1ns/1ps
module ictx_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Trap sequencing
    input wire logic global_int_disable,
    input wire logic injected_trap_instr,
    input wire logic int_acknowledge_n,
    input wire logic vec_fetch,
    input wire logic fetch_dummy,
    input wire logic repeat_active,
    input wire logic op_clear_global_disable,
    input wire logic op_return_and_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    trap_sets_disable_a: assert property (injected_trap_instr |-> global_int_disable)
        else $error("trap left interrupts on");
    ack_hold_off_a: assert property (injected_trap_instr |-> int_acknowledge_n[*3])
        else $error("early acknowledge");
    ack_bound_a: assert property (injected_trap_instr |-> ##[3:60] !int_acknowledge_n)
        else $error("no acknowledge");
    vec_with_ack_a: assert property ($fell(int_acknowledge_n) |->
        vec_fetch && $past(fetch_dummy, 2))
        else $error("vector fetch off");
    dummy_fetch_a: assert property (injected_trap_instr |=> fetch_dummy[*2])
        else $error("real fetch in trap");
    enable_cause_a: assert property ($fell(global_int_disable) |->
        $past(op_return_and_enable) || $past(op_clear_global_disable))
        else $error("enabled without cause");
    repeat_defer_a: assert property (repeat_active |=> !injected_trap_instr)
        else $error("trap in repeat");
    clear_shield_a: assert property (op_clear_global_disable |=> !injected_trap_instr[*2])
        else $error("trap after enable");
    cover property (injected_trap_instr);
    cover property ($fell(global_int_disable));
    cover property (repeat_active ##1 !repeat_active);
endmodule // ictx_monitor

bind ictx_top ictx_monitor u_ictx_monitor (.clk(clk), .rst_b(rst_b),
    .global_int_disable(global_int_disable), .injected_trap_instr(injected_trap_instr),
    .int_acknowledge_n(int_acknowledge_n), .vec_fetch(vec_fetch), .fetch_dummy(fetch_dummy),
    .repeat_active(repeat_active), .op_clear_global_disable(op_clear_global_disable),
    .op_return_and_enable(op_return_and_enable));

// ### testbench/ictx_partner.sv
// Far-side model: interrupt pins and the bus hold requester.
`timescale 1ns/1ps
module ictx_partner (
    // Clock and wish of the bench
    input wire logic clk,
    input wire logic hold_on,
    // Pins toward the block
    output logic [ictx_pkg::NUM_INT-1:0] ext_int_n,
    output logic bus_hold_req_n
);
    initial ext_int_n = 4'hf;
    initial bus_hold_req_n = 1'b1;
    // The requester asks for the bus one cycle after the bench wishes it.
    always @(posedge clk) bus_hold_req_n <= !hold_on;
    // A pin falls once and returns to its pull-up level, so one edge is seen.
    task automatic fire(input int i);
        fork begin
            ext_int_n[i] <= 1'b0;
            repeat (3) @(posedge clk);
            ext_int_n[i] <= 1'b1;
        end join_none
    endtask
endmodule // ictx_partner

// ### testbench/tb_interrupt_context_latency.sv
// Bench of the interrupt context block against a queue model.
`timescale 1ns/1ps
module tb_interrupt_context_latency;
    logic clk, rst_b, hsel, hwrite, hrdy, mem_wait, dis, pv, rv, st_v, ack_n, req_n, gnt_n, resp;
    logic [1:0] htrans;
    logic [2:0] dfr;
    logic [3:0] int_n;
    logic [7:0] ops;
    logic [15:0] ret_pc, vaddr, rpc;
    logic [31:0] haddr, hwdata, hrdata, rd, seed, sz_in, sz_out;
    logic [15:0] stk[$];
    ictx_pkg::ictx_regs_t live, restored, shadow;
    int compares, miscompares, n;
    ictx_top u_ictx_top (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(resp), .hrdata(hrdata), .ext_int_n(int_n),
        .bus_hold_req_n(req_n), .bus_hold_grant_n(gnt_n), .int_acknowledge_n(ack_n),
        .instr_done(ops[7]), .op_call(ops[0]), .op_ret(ops[1]),
        .op_return_from_interrupt(ops[2]), .op_return_and_enable(ops[3]),
        .op_set_global_disable(ops[4]), .op_clear_global_disable(ops[5]),
        .op_store_status_zero(ops[6]), .status_zero_in(sz_in), .return_pc(ret_pc),
        .repeat_active(dfr[0]), .multicycle_busy(dfr[2]), .mem_wait(mem_wait),
        .global_int_disable(dis), .injected_trap_instr(), .fetch_dummy(), .vec_fetch(),
        .vec_addr(vaddr), .resume_valid(pv), .resume_pc(rpc), .status_store_valid(st_v),
        .status_store_data(sz_out), .live_regs(live), .restore_valid(rv),
        .restored_regs(restored));
    ictx_partner u_ictx_partner (.clk(clk), .hold_on(dfr[1]), .ext_int_n(int_n),
        .bus_hold_req_n(req_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string nm, input logic [352:0] seen, input logic [352:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One word transfer; a slave that never answers ends the run.
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        {hsel, haddr, hwrite, htrans} <= {1'b1, 24'h0, a, w, 2'h2};
        for (int p = 0; p < 2; p++) begin
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (hrdy !== 1'b1 && k < 50);
            if (hrdy !== 1'b1) begin
                miscompares++;
                end_sim();
            end
            {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        end
        rd = hrdata;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        ahb(a, 1'b0, 32'h0);
        check(nm, rd, e);
        check("resp", resp, 1'b0);
    endtask
    task automatic strobe(input int b);
        @(posedge clk);
        ops[b] <= 1'b1;
        @(posedge clk);
        ops <= 8'h0;
        @(negedge clk);
    endtask
    task automatic arm();
        @(posedge clk);
        for (int j = 0; j < ictx_pkg::NUM_SHADOW; j++)
            live[j] <= rnd();
        ret_pc <= 16'(rnd());
        sz_in <= rnd() & 32'hfffffffe;
    endtask
    task automatic wait_ack(input int lim);
        while (ack_n !== 1'b0 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (ack_n !== 1'b0) begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic enable();
        for (int b = 4; b < 9; b++)
            strobe(b > 5 ? 7 : b);
        check("disable", dis, 1'b0);
    endtask
    task automatic took(input int i);
        stk.push_back(ret_pc);
        shadow = live;
        check("disable", dis, 1'b1);
        check("vector", vaddr, 16'h0100 + 16'(2 * i));
        rchk("pending", ictx_pkg::OFS_PENDING, 32'h0);
        rchk("top", ictx_pkg::OFS_TOS, {16'h0, stk[$]});
    endtask
    // The store of status word zero lands on the very edge of the trap.
    task automatic trap(input int i);
        arm();
        @(posedge clk);
        u_ictx_partner.fire(i);
        repeat (4) @(posedge clk);
        ops[6] <= 1'b1;
        @(posedge clk);
        ops[6] <= 1'b0;
        @(negedge clk);
        check("store", {st_v, sz_out}, {1'b1, sz_in | 32'h1});
        n = 5;
        wait_ack(20);
        check("latency", n, 8);
        took(i);
    endtask
    task automatic leave(input logic e);
        arm();
        strobe(e ? 3 : 2);
        shadow[ictx_pkg::SH_STATUS0][0] = !e;
        shadow[ictx_pkg::SH_STATUS1][0] = live[ictx_pkg::SH_STATUS1][0];
        check("restore", {rv, restored}, {1'b1, shadow});
        check("resume", {pv, rpc}, {1'b1, stk.pop_back()});
        check("disable", dis, !e);
    endtask
    initial begin
        {rst_b, hsel, hwrite, mem_wait, ops, dfr, htrans, haddr, hwdata} = '0;
        {sz_in, ret_pc, live} = '0;
        {seed, compares, miscompares} = {32'hb07f, 64'h0};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rchk("control", ictx_pkg::OFS_CTRL, 32'h1);
        ahb(ictx_pkg::OFS_STATUS, 1'b1, 32'hffff);
        rchk("status", ictx_pkg::OFS_STATUS, 32'h1);
        rchk("unmapped", 8'h40, 32'h0);
        ahb(ictx_pkg::OFS_MASK, 1'b1, 32'hf);
        ahb(ictx_pkg::OFS_VEC_BASE, 1'b1, 32'h100);
        u_ictx_partner.fire(2);
        repeat (4) @(posedge clk);
        rchk("flag", ictx_pkg::OFS_PENDING, 32'h4);
        ahb(ictx_pkg::OFS_PENDING, 1'b1, 32'h4);
        rchk("cleared", ictx_pkg::OFS_PENDING, 32'h0);
        enable();
        trap(0);
        enable();
        trap(1);
        leave(1'b0);
        enable();
        for (int k = 0; k < 3; k++) begin
            arm();
            @(posedge clk);
            dfr[k] <= 1'b1;
            u_ictx_partner.fire(k);
            repeat (20) @(negedge clk);
            check("held", ack_n, 1'b1);
            if (k == 1) check("grant", gnt_n, 1'b0);
            @(posedge clk);
            {dfr, n} <= '0;
            @(negedge clk);
            wait_ack(30);
            check("late", ack_n, 1'b0);
            took(k);
            leave(1'b1);
        end
        ahb(ictx_pkg::OFS_CTRL, 1'b1, 32'h2);
        {dfr[1], mem_wait} <= 2'h3;
        trap(3);
        check("stretch", ack_n, 1'b0);
        {dfr, mem_wait} <= '0;
        leave(1'b1);
        strobe(0);
        stk.push_back(ret_pc);
        strobe(1);
        check("ret", {pv, rv, rpc}, {2'b10, stk.pop_back()});
        for (int j = 0; j < 8; j++) begin
            arm();
            strobe(0);
            if (stk.size() < 8)
                stk.push_back(ret_pc);
        end
        ahb(ictx_pkg::OFS_STATUS, 1'b0, 32'h0);
        check("depth", rd & 32'h3ff, 32'h100 | (stk.size() << 4));
        end_sim();
    end
endmodule // tb_interrupt_context_latency
